// ### src/rssx_exec.sv
`timescale 1ns/1ps
`include "rssx_consts.svh"

// Notes on behaviour
// - Rotate-to-work: work[6:0] takes operand[7:1], work[7] old borrow, borrow operand[0].
// - Rotate-to-work never writes data memory and changes only the work register and borrow.
// - Subtract-to-work loads work with work - operand - ~borrow and updates all four flags.
// - Either subtract leaves borrow_out_bit 0 on a negative result, 1 on zero or positive.
// - Subtract-to-memory computes and flags the same but writes the difference to memory.
// - Decrement-skip writes operand minus one back to memory and skips on a zero result.
// - A skip inserts one dummy cycle during which the next fetched instruction is discarded.
// - A nonzero decrement result continues normally with no skip.
module rssx_exec
    import rssx_pkg::*;
(
    input wire logic core_clk,                          // Core clock, 250 MHz
    input wire logic srst,                              // Synchronous reset, active high
    input wire logic op_valid,                          // Instruction present this cycle
    input rssx_req_type req,                            // Opcode and memory operand
    input wire logic wr_load,                           // Load work register from outside
    input wire logic [`RSSX_BYTE_W-1:0] wr_load_data,   // Value for wr_load
    output logic [`RSSX_BYTE_W-1:0] work_register,      // Work register
    output rssx_flags_type flags,                       // Status flags
    output logic mem_we,                                // Data memory write strobe
    output logic [`RSSX_BYTE_W-1:0] mem_wdata,          // Data memory write value
    output logic skip,                                  // Dummy cycle, next instruction dropped
    output logic done                                   // Instruction completed last cycle
);
    logic [`RSSX_BYTE_W-1:0] work_r;
    logic [`RSSX_BYTE_W-1:0] work_nxt;
    rssx_flags_type flags_r;
    rssx_flags_type flags_nxt;
    logic mem_we_r;
    logic mem_we_nxt;
    logic [`RSSX_BYTE_W-1:0] mem_wdata_r;
    logic [`RSSX_BYTE_W-1:0] mem_wdata_nxt;
    logic skip_r;
    logic skip_nxt;
    logic done_r;
    logic done_nxt;
    rssx_alu_out_type alu_res;

    wire take;
    wire is_rot;
    wire is_sbw;
    wire is_sbm;
    wire is_dsz;
    wire is_sub;
    wire load_take;

    rssx_alu u_alu (
        .op(req.op),
        .operand(req.operand),
        .work(work_r),
        .borrow_in(flags_r.borrow_out_bit),
        .res(alu_res)
    );

    // The instruction fetched during a skip cycle is discarded
    assign take = op_valid & ~skip_r;
    assign is_rot = take & (req.op == RSSX_OP_ROT);
    assign is_sbw = take & (req.op == RSSX_OP_SBW);
    assign is_sbm = take & (req.op == RSSX_OP_SBM);
    assign is_dsz = take & (req.op == RSSX_OP_DSZ);
    assign is_sub = is_sbw | is_sbm;
    // An executing instruction has priority over an outside load
    assign load_take = wr_load & ~take;

    assign work_nxt = (is_rot | is_sbw) ? alu_res.result
                    : (load_take ? wr_load_data : work_r);
    assign flags_nxt.borrow_out_bit = (is_rot | is_sub) ? alu_res.flags.borrow_out_bit
                                    : flags_r.borrow_out_bit;
    assign flags_nxt.half_borrow_flag = is_sub ? alu_res.flags.half_borrow_flag
                                      : flags_r.half_borrow_flag;
    assign flags_nxt.result_nil_flag = is_sub ? alu_res.flags.result_nil_flag
                                     : flags_r.result_nil_flag;
    assign flags_nxt.sign_wrap_flag = is_sub ? alu_res.flags.sign_wrap_flag
                                    : flags_r.sign_wrap_flag;
    // Rotate never reaches the memory write path
    assign mem_we_nxt = is_sbm | is_dsz;
    assign mem_wdata_nxt = mem_we_nxt ? alu_res.result : mem_wdata_r;
    assign skip_nxt = is_dsz & alu_res.flags.result_nil_flag;
    assign done_nxt = take;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            work_r <= `RSSX_WORK_RST;
            flags_r <= `RSSX_FLAGS_RST;
            mem_we_r <= 1'b0;
            mem_wdata_r <= `RSSX_ZERO_BYTE;
            skip_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            work_r <= work_nxt;
            flags_r <= flags_nxt;
            mem_we_r <= mem_we_nxt;
            mem_wdata_r <= mem_wdata_nxt;
            skip_r <= skip_nxt;
            done_r <= done_nxt;
        end
    end

    assign work_register = work_r;
    assign flags = flags_r;
    assign mem_we = mem_we_r;
    assign mem_wdata = mem_wdata_r;
    assign skip = skip_r;
    assign done = done_r;

    // Reference values used only by the checks below
    wire [`RSSX_BYTE_W:0] ref_need;
    wire ref_no_borrow;
    wire [`RSSX_BYTE_W-1:0] ref_diff;
    wire [`RSSX_NIB_W:0] ref_need_lo;
    wire ref_half;
    wire ref_wrap;

    assign ref_need = {1'b0, req.operand} + {`RSSX_ZERO_BYTE, ~flags_r.borrow_out_bit};
    assign ref_no_borrow = ({1'b0, work_r} >= ref_need);
    assign ref_diff = work_r - req.operand - {7'h00, ~flags_r.borrow_out_bit};
    assign ref_need_lo = {1'b0, req.operand[`RSSX_NIB_W-1:0]}
                         + {`RSSX_ZERO_NIB, ~flags_r.borrow_out_bit};
    assign ref_half = ({1'b0, work_r[`RSSX_NIB_W-1:0]} < ref_need_lo);
    assign ref_wrap = ($signed({work_r[`RSSX_MSB], work_r})
                       - $signed({req.operand[`RSSX_MSB], req.operand})
                       - $signed({1'b0, ~flags_r.borrow_out_bit}))
                      != $signed({ref_diff[`RSSX_MSB], ref_diff});

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    a_rot_work_bits: assert property (
        is_rot |=> (work_r == {$past(flags_r.borrow_out_bit), $past(req.operand[7:1])})
                   && (flags_r.borrow_out_bit == $past(req.operand[0])))
        else $error("rotate result or borrow wrong");

    a_rot_mem_kept: assert property (
        is_rot |=> !mem_we_r && $stable(flags_r.sign_wrap_flag)
                   && $stable(flags_r.result_nil_flag) && $stable(mem_wdata_r))
        else $error("rotate touched memory or other flags");

    a_sbw_work_diff: assert property (
        is_sbw |=> (work_r == $past(ref_diff)) && !mem_we_r)
        else $error("subtract to work result wrong");

    a_sub_borrow_sign: assert property (
        is_sub |=> flags_r.borrow_out_bit == $past(ref_no_borrow))
        else $error("borrow flag does not follow sign of result");

    a_sbm_mem_diff: assert property (
        is_sbm |=> mem_we_r && (mem_wdata_r == $past(ref_diff)) && $stable(work_r))
        else $error("subtract to memory result wrong");

    a_dsz_mem_dec: assert property (
        is_dsz |=> mem_we_r && (mem_wdata_r == $past(req.operand) - 8'h01))
        else $error("decrement value not written");

    a_dsz_skip_once: assert property (
        (is_dsz && req.operand == 8'h01) |=> skip_r && !done_nxt ##1 !skip_r)
        else $error("skip cycle missing or too long");

    a_dsz_no_skip: assert property (
        (is_dsz && req.operand != 8'h01) |=> !skip_r)
        else $error("skip raised on nonzero result");

    a_sub_flag_set: assert property (
        is_sub |=> (flags_r.result_nil_flag == ($past(ref_diff) == 8'h00))
                   && (flags_r.half_borrow_flag == $past(ref_half))
                   && (flags_r.sign_wrap_flag == $past(ref_wrap)))
        else $error("subtract status flags wrong");

    a_sbw_nil_match: assert property (
        is_sbw |=> flags_r.result_nil_flag == (work_r == `RSSX_ZERO_BYTE))
        else $error("nil flag does not match work result");

    // Skip cycle: an instruction offered there must leave no trace; an outside load there is still applied
    a_skip_drop_op: assert property (
        skip_r |=> !done_r && !mem_we_r && !skip_r && $stable(flags_r))
        else $error("instruction in skip cycle was not dropped");

    a_dsz_next_runs: assert property (
        (is_dsz && req.operand != `RSSX_ONE_BYTE) ##1 op_valid |=> done_r)
        else $error("instruction after nonzero decrement not run");

    a_dsz_flags_kept: assert property (
        is_dsz |=> $stable(flags_r) && $stable(work_r) && done_r)
        else $error("decrement changed flags or work");

    a_rot_half_kept: assert property (
        is_rot |=> $stable(flags_r.half_borrow_flag) && done_r)
        else $error("rotate changed half borrow");

    a_rot_no_skip: assert property (
        is_rot |=> !skip_r)
        else $error("rotate raised a skip");

    a_mem_we_source: assert property (
        mem_we_r |-> $past(is_sbm || is_dsz))
        else $error("memory write without a writing instruction");

    // Strobes and the outside load
    a_load_work: assert property (
        load_take |=> (work_r == $past(wr_load_data)) && $stable(flags_r) && !done_r)
        else $error("work load not applied");

    a_done_pulse: assert property (
        take |=> done_r)
        else $error("done missing after a taken instruction");

    a_done_idle: assert property (
        !take |=> !done_r)
        else $error("done raised with nothing taken");

    // Default disable lifted so the reset values themselves are seen
    a_reset_clears: assert property (disable iff (1'b0)
        srst |=> (work_r == `RSSX_WORK_RST) && !mem_we_r && !skip_r && !done_r)
        else $error("reset left state behind");

    c_rot_seen: cover property (is_rot ##1 done_r);
    c_sbm_wrap: cover property (is_sbm ##1 flags_r.sign_wrap_flag);
    c_dsz_skip: cover property (is_dsz ##1 skip_r);
    c_skip_drop: cover property (skip_r && op_valid ##1 !done_r);
    c_load_seen: cover property (load_take ##1 !done_r);
endmodule

// ### src/rssx_consts.svh
`ifndef RSSX_CONSTS_SVH
`define RSSX_CONSTS_SVH

`define RSSX_BYTE_W 8
`define RSSX_MSB 7
`define RSSX_NIB_W 4
`define RSSX_ZERO_BYTE 8'h00
`define RSSX_ONE_BYTE 8'h01
`define RSSX_ZERO_NIB 4'h0
`define RSSX_WORK_RST 8'h00
`define RSSX_FLAGS_RST 4'h0

`endif

// ### src/rssx_pkg.sv
package rssx_pkg;
    `include "rssx_consts.svh"

    typedef enum logic [1:0] {
        RSSX_OP_ROT,
        RSSX_OP_SBW,
        RSSX_OP_SBM,
        RSSX_OP_DSZ
    } rssx_op_type;

    typedef struct packed {
        rssx_op_type op;
        logic [`RSSX_BYTE_W-1:0] operand;
    } rssx_req_type;

    typedef struct packed {
        logic borrow_out_bit;
        logic half_borrow_flag;
        logic result_nil_flag;
        logic sign_wrap_flag;
    } rssx_flags_type;

    typedef struct packed {
        logic [`RSSX_BYTE_W-1:0] result;
        rssx_flags_type flags;
    } rssx_alu_out_type;
endpackage

// ### src/rssx_alu.sv
`timescale 1ns/1ps
`include "rssx_consts.svh"

module rssx_alu
    import rssx_pkg::*;
(
    input rssx_op_type op,                      // Operation selector
    input logic [`RSSX_BYTE_W-1:0] operand,     // Memory operand
    input logic [`RSSX_BYTE_W-1:0] work,        // Current work register
    input logic borrow_in,                      // Current borrow_out_bit
    output rssx_alu_out_type res                // Result and candidate flags
);
    logic [`RSSX_BYTE_W-1:0] rot_val;
    wire [`RSSX_BYTE_W:0] sub_full;
    wire [`RSSX_NIB_W:0] nib_full;
    wire [`RSSX_BYTE_W-1:0] dec_val;
    wire [`RSSX_BYTE_W-1:0] sub_val;
    wire is_rot;
    wire is_dec;

    genvar i;
    generate
        for (i = 0; i < `RSSX_MSB; i++) begin : g_rot
            assign rot_val[i] = operand[i+1];
        end
    endgenerate
    assign rot_val[`RSSX_MSB] = borrow_in;

    // Borrow in is the complement of the stored flag
    assign sub_full = {1'b0, work} - {1'b0, operand} - {`RSSX_ZERO_BYTE, ~borrow_in};
    assign nib_full = {1'b0, work[`RSSX_NIB_W-1:0]} - {1'b0, operand[`RSSX_NIB_W-1:0]}
                      - {`RSSX_ZERO_NIB, ~borrow_in};
    assign sub_val = sub_full[`RSSX_BYTE_W-1:0];
    assign dec_val = operand - `RSSX_ONE_BYTE;
    assign is_rot = (op == RSSX_OP_ROT);
    assign is_dec = (op == RSSX_OP_DSZ);

    assign res.result = is_rot ? rot_val : (is_dec ? dec_val : sub_val);
    // Flag is set when no borrow occurred
    assign res.flags.borrow_out_bit = is_rot ? operand[0] : ~sub_full[`RSSX_BYTE_W];
    assign res.flags.half_borrow_flag = nib_full[`RSSX_NIB_W];
    assign res.flags.result_nil_flag = (res.result == `RSSX_ZERO_BYTE);
    assign res.flags.sign_wrap_flag = (work[`RSSX_MSB] ^ operand[`RSSX_MSB])
                                      & (work[`RSSX_MSB] ^ sub_val[`RSSX_MSB]);
endmodule

// ### sim/rssx_dmem_model.sv
`timescale 1ns/1ps

module rssx_dmem_model (
    input wire logic core_clk,          // Core clock
    input wire logic srst,              // Synchronous reset
    input wire logic [1:0] addr,        // Byte address of the offered instruction
    input wire logic mem_we,            // Write strobe from the datapath
    input wire logic [7:0] mem_wdata,   // Write value from the datapath
    output logic [7:0] rdata            // Operand at addr
);
    logic [7:0] mem_r [4];
    logic [1:0] wa_r;

    assign rdata = mem_r[addr];

    // Write lands one edge after the take, so the address is held a cycle
    always_ff @(posedge core_clk) begin
        if (srst) begin
            mem_r <= '{8'h03, 8'h01, 8'h80, 8'hFF};
        end else if (mem_we) begin
            mem_r[wa_r] <= mem_wdata;
        end
        wa_r <= addr;
    end
endmodule

// ### sim/tb.sv
`timescale 1ns/1ps

module tb
    import rssx_pkg::*;
;
    localparam logic [13:0] DIRS [8] = '{14'h0100, 14'h2C00, 14'h3755, 14'h3A00,
        14'h2600, 14'h2000, 14'h3800, 14'h2A00};
    logic core_clk, srst, op_valid, wr_load, mem_we, skip, done;
    logic [7:0] wr_load_data, work_register, mem_wdata, rdata, e_work, e_wd;
    logic [1:0] addr;
    logic e_we, e_skip, e_done;
    logic [31:0] xs = 32'h647D;
    rssx_op_type cur_op;
    rssx_req_type req;
    rssx_flags_type flags, e_flags;
    int n_fail = 0;
    int samples_checked = 0;

    assign req = {cur_op, rdata};

    rssx_exec rssx_exec_i (.core_clk(core_clk), .srst(srst), .op_valid(op_valid), .req(req),
        .wr_load(wr_load), .wr_load_data(wr_load_data), .work_register(work_register),
        .flags(flags), .mem_we(mem_we), .mem_wdata(mem_wdata), .skip(skip), .done(done));
    rssx_dmem_model rssx_dmem_model_i (.core_clk(core_clk), .srst(srst), .addr(addr),
        .mem_we(mem_we), .mem_wdata(mem_wdata), .rdata(rdata));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic results();
        $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Reference step for one edge, using the inputs that edge samples
    function automatic void upd();
        logic taken;
        logic [8:0] d;
        logic [4:0] h;
        taken = op_valid && !e_skip && !srst;
        d = {1'b0, e_work} - {1'b0, rdata} - {8'h00, ~e_flags.borrow_out_bit};
        h = {1'b0, e_work[3:0]} - {1'b0, rdata[3:0]} - {4'h0, ~e_flags.borrow_out_bit};
        e_done = taken;
        e_we = 1'b0;
        e_skip = 1'b0;
        if (srst) begin
            e_work = 8'h00;
            e_flags = 4'h0;
            e_wd = 8'h00;
        end else if (taken && cur_op == RSSX_OP_ROT) begin
            e_work = {e_flags.borrow_out_bit, rdata[7:1]};
            e_flags.borrow_out_bit = rdata[0];
        end else if (taken && cur_op == RSSX_OP_DSZ) begin
            e_we = 1'b1;
            e_wd = rdata - 8'h01;
            e_skip = (rdata == 8'h01);
        end else if (taken) begin
            e_flags = {~d[8], h[4], d[7:0] == 8'h00,
                (e_work[7] != rdata[7]) && (d[7] != e_work[7])};
            if (cur_op == RSSX_OP_SBW) begin
                e_work = d[7:0];
            end else begin
                e_we = 1'b1;
                e_wd = d[7:0];
            end
        end else if (wr_load) begin
            e_work = wr_load_data;
        end
    endfunction

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    initial begin
        logic [31:0] e;
        srst = 1'b1;
        op_valid = 1'b0;
        wr_load = 1'b0;
        wr_load_data = 8'h00;
        cur_op = RSSX_OP_ROT;
        addr = 2'h0;
        repeat (20) begin
            @(posedge core_clk);
            upd();
        end
        srst <= 1'b0;
        for (int k = 0; k < 3000; k++) begin
            @(posedge core_clk);
            chk(work_register, e_work, "work");
            chk({4'h0, flags}, {4'h0, e_flags}, "flags");
            chk({7'h00, mem_we}, {7'h00, e_we}, "write strobe");
            chk(mem_wdata, e_wd, "write data");
            chk({7'h00, skip}, {7'h00, e_skip}, "skip");
            chk({7'h00, done}, {7'h00, e_done}, "done");
            upd();
            xs = next_rand(xs);
            // Corner cases first: negative borrow, skip with a dropped op, load ignored
            e = (k < 8) ? {18'h0, DIRS[k]}
                : {18'h0, xs[0] | xs[1], xs[3:2], xs[5:4], xs[6] & xs[7], xs[15:8]};
            op_valid <= e[13];
            cur_op <= rssx_op_type'(e[12:11]);
            addr <= e[10:9];
            wr_load <= e[8];
            wr_load_data <= e[7:0];
            // Short reset in mid-run; traffic goes on right after it
            srst <= (k >= 1500) && (k < 1503);
        end
        results();
    end

    // Run needs about 12.1 us; give it margin
    initial begin
        #20000;
        n_fail++;
        results();
    end
endmodule
